// ===== design/rsc_pkg.sv
// rsc_pkg: constants and carrier types of the reset source classifier.
// assumes a single 200 MHz core clock; one tcl equals one clock cycle.
package rsc_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned MIN_PULSE_NS    = 500;
  localparam int unsigned MIN_PULSE_TCL   = 4;
  // least time rounds up
  localparam int unsigned MIN_PULSE_CYC_NS =
    (MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SHORT_MIN_CYC =
    (MIN_PULSE_CYC_NS > MIN_PULSE_TCL) ? MIN_PULSE_CYC_NS : MIN_PULSE_TCL;
  localparam int unsigned LONG_BASE_TCL   = 1032;
  localparam int unsigned LONG_EXTRA_TCL  = 12;
  localparam int unsigned LONG_MIN_CYC    =
    LONG_BASE_TCL + LONG_EXTRA_TCL + SHORT_MIN_CYC;
  localparam int unsigned SEQ_LEN_TCL     = 1024;
  localparam int unsigned RESAMPLE_TCL    = 8;
  localparam int unsigned CNT_W           = 11;

  // ---------------------------------------------------------------
  // configuration register layout
  // ---------------------------------------------------------------
  localparam int unsigned BIDIR_EN_BIT    = 3;
  localparam logic [15:0] SYSCFG_RESET    = 16'h0000;

  // ---------------------------------------------------------------
  // reset source flags
  // ---------------------------------------------------------------
  typedef struct packed {
    logic poweron_flag;
    logic long_hw_flag;
    logic short_hw_flag;
    logic soft_flag;
    logic wdog_flag;
  } rsc_flags_t;

  localparam rsc_flags_t FLAGS_PON   = 5'b11110;
  localparam rsc_flags_t FLAGS_LONG  = 5'b01110;
  localparam rsc_flags_t FLAGS_SHORT = 5'b00110;

  typedef enum logic [2:0] {
    RSC_IDLE   = 3'b000,
    RSC_ASYNC  = 3'b001,
    RSC_SYNC   = 3'b011,
    RSC_SEQ    = 3'b010,
    RSC_CHECK  = 3'b110,
    RSC_INIT   = 3'b111
  } rsc_state_t;

endpackage

// ===== design/rsc_filter.sv
// rsc_filter: synchroniser and glitch filter for the reset input.
// assumes the input is asynchronous to clk_i.
`timescale 1ns/10ps
module rsc_filter #(
  parameter int unsigned WIDTH_CYC = rsc_pkg::SHORT_MIN_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_n_i,
  output logic      filt_n_o
);
  logic       s1_reg;
  logic       s2_reg;
  logic [7:0] cnt_reg;

  // ---------------------------------------------------------------
  // synchroniser
  // ---------------------------------------------------------------
  // R13 synchronise reset input
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
    end else begin
      s1_reg <= pin_n_i;
      s2_reg <= s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // filter: output follows only a level stable for the full width
  // ---------------------------------------------------------------
  // R13 reject short glitches
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg  <= 8'h00;
      filt_n_o <= 1'b1;
    end else if (s2_reg == filt_n_o) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg == 8'(WIDTH_CYC - 1)) begin
      cnt_reg  <= 8'h00;
      filt_n_o <= s2_reg;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule

// ===== design/rsc_top.sv
// rsc_top: reset entry, classification and pin control.
// assumes pin levels are asynchronous; init_done, bidir set, soft and
// watchdog requests are one-cycle pulses from core logic on clk_i.
//
// Overview of operation
// R01 - bidir enabled: pull reset pin low
// R02 - reset out low until end of init
// R03 - pullup config: pullup on at sequence end
// R04 - reset low with powerdown pin low: async
// R05 - pulldown on powerdown pin while reset low
// R06 - short pulse with powerdown high: sync reset
// R07 - powerdown falls during hold: switch async
// R08 - flags set per reset class
// R09 - short/long class by hold length
// R10 - bidir sync reset drives pin 1024 tcl
// R11 - bidir enable bit 3, cleared by reset
// R12 - resample filtered input 8 tcl later
// R13 - reset input synchronised and glitch filtered
`timescale 1ns/10ps
module rsc_top #(
  parameter int unsigned LONG_CYC = rsc_pkg::LONG_MIN_CYC,
  parameter int unsigned SEQ_CYC  = rsc_pkg::SEQ_LEN_TCL
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         reset_in_n_i,
  input  wire logic         reset_powerdown_pin_i,
  input  wire logic         end_of_init_instr_i,
  input  wire logic         bidir_set_i,
  input  wire logic         powerdown_pullup_config_i,
  input  wire logic         soft_req_i,
  input  wire logic         wdog_req_i,
  output logic              reset_in_n_o,
  output logic              reset_in_n_oe_o,
  output logic              reset_out_n_o,
  output logic              rpd_pulldown_o,
  output logic              rpd_pullup_o,
  output logic              core_reset_o,
  output logic              async_reset_o,
  output logic              bidir_reset_enable_o,
  output rsc_pkg::rsc_flags_t flags_o
);
  logic                  filt_n;
  logic                  rpd_s1_reg;
  logic                  rpd_reg;
  rsc_pkg::rsc_state_t   state_reg;
  logic [11:0]           hold_reg;
  logic [10:0]           seq_reg;
  logic [3:0]            chk_reg;
  logic                  pon_reg;
  logic                  sw_seq_reg;
  logic                  wd_seq_reg;

  rsc_filter #(
    .WIDTH_CYC (rsc_pkg::SHORT_MIN_CYC)
  ) u_filter (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .pin_n_i  (reset_in_n_i),
    .filt_n_o (filt_n)
  );

  // ---------------------------------------------------------------
  // powerdown pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rpd_s1_reg <= 1'b0;
      rpd_reg    <= 1'b0;
    end else begin
      rpd_s1_reg <= reset_powerdown_pin_i;
      rpd_reg    <= rpd_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // classification state machine
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg  <= rsc_pkg::RSC_ASYNC;
      hold_reg   <= 12'h000;
      seq_reg    <= 11'h000;
      chk_reg    <= 4'h0;
      pon_reg    <= 1'b1;
      sw_seq_reg <= 1'b0;
      wd_seq_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        rsc_pkg::RSC_IDLE, rsc_pkg::RSC_INIT: begin
          hold_reg <= 12'h000;
          if (!filt_n) begin
            // R04 async when powerdown low
            // R06 sync when powerdown high
            state_reg <= rpd_reg ? rsc_pkg::RSC_SYNC
                                 : rsc_pkg::RSC_ASYNC;
            sw_seq_reg <= 1'b0;
          end else if (soft_req_i || wdog_req_i) begin
            state_reg  <= rsc_pkg::RSC_SEQ;
            seq_reg    <= 11'h000;
            sw_seq_reg <= 1'b1;
            wd_seq_reg <= wdog_req_i;
          end
        end
        rsc_pkg::RSC_ASYNC: begin
          if (filt_n && rpd_reg) begin
            state_reg <= rsc_pkg::RSC_SEQ;
            seq_reg   <= 11'h000;
          end else if (filt_n) begin
            state_reg <= rsc_pkg::RSC_SEQ;
            seq_reg   <= 11'h000;
          end
        end
        rsc_pkg::RSC_SYNC, rsc_pkg::RSC_SEQ: begin
          if (!filt_n && hold_reg != 12'hfff) begin
            hold_reg <= hold_reg + 12'h001;
          end
          // R07 powerdown fall forces async
          if (!filt_n && !rpd_reg && !sw_seq_reg) begin
            state_reg <= rsc_pkg::RSC_ASYNC;
          end else if (state_reg == rsc_pkg::RSC_SYNC) begin
            state_reg <= rsc_pkg::RSC_SEQ;
            seq_reg   <= 11'h000;
          end else if (seq_reg == 11'(SEQ_CYC - 1)) begin
            if (filt_n || sw_seq_reg) begin
              state_reg <= rsc_pkg::RSC_CHECK;
              chk_reg   <= 4'h0;
            end
          end else begin
            seq_reg <= seq_reg + 11'h001;
          end
        end
        rsc_pkg::RSC_CHECK: begin
          // R12 resample after 8 tcl
          if (chk_reg == 4'(rsc_pkg::RESAMPLE_TCL - 1)) begin
            if (!filt_n) begin
              state_reg  <= rsc_pkg::RSC_SYNC;
              sw_seq_reg <= 1'b0;
              hold_reg   <= 12'h000;
            end else begin
              state_reg <= rsc_pkg::RSC_INIT;
              pon_reg   <= 1'b0;
            end
          end else begin
            chk_reg <= chk_reg + 4'h1;
          end
        end
        default: state_reg <= rsc_pkg::RSC_ASYNC;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // reset source flags
  // ---------------------------------------------------------------
  // R08 flags per class
  // R09 short or long by hold
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_o <= rsc_pkg::FLAGS_PON;
    end else if (state_reg == rsc_pkg::RSC_ASYNC) begin
      flags_o <= pon_reg ? rsc_pkg::FLAGS_PON : rsc_pkg::FLAGS_LONG;
    end else if (state_reg == rsc_pkg::RSC_SYNC) begin
      // every synchronous hardware reset starts short, upgraded once held long; soft and watchdog skip RSC_SYNC
      flags_o <= rsc_pkg::FLAGS_SHORT;
    end else if (state_reg == rsc_pkg::RSC_SEQ && !sw_seq_reg
                 && !flags_o.long_hw_flag) begin
      if (32'(hold_reg) + 32'd1 >= LONG_CYC) begin
        flags_o <= rsc_pkg::FLAGS_LONG;
      end
    end else if (state_reg == rsc_pkg::RSC_SEQ && sw_seq_reg
                 && seq_reg == 11'h000) begin
      flags_o <= '{poweron_flag:  1'b0, long_hw_flag: 1'b0,
                   short_hw_flag: 1'b0, soft_flag:    1'b1,
                   wdog_flag:     wd_seq_reg};
    end
  end

  // ---------------------------------------------------------------
  // bidirectional enable, pin drives
  // ---------------------------------------------------------------
  // R11 enable bit cleared by reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bidir_reset_enable_o <= rsc_pkg::SYSCFG_RESET[rsc_pkg::BIDIR_EN_BIT];
    end else if (state_reg != rsc_pkg::RSC_IDLE
                 && state_reg != rsc_pkg::RSC_INIT) begin
      bidir_reset_enable_o <= 1'b0;
    end else if (bidir_set_i && state_reg == rsc_pkg::RSC_INIT) begin
      bidir_reset_enable_o <= 1'b1;
    end
  end

  logic bidir_seq_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bidir_seq_reg <= 1'b0;
    end else if (state_reg == rsc_pkg::RSC_IDLE
                 || state_reg == rsc_pkg::RSC_INIT) begin
      bidir_seq_reg <= bidir_reset_enable_o;
    end else if (!rpd_reg) begin
      bidir_seq_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_in_n_o    <= 1'b0;
      reset_in_n_oe_o <= 1'b0;
      reset_out_n_o   <= 1'b0;
      rpd_pulldown_o  <= 1'b0;
      rpd_pullup_o    <= 1'b0;
      core_reset_o    <= 1'b1;
      async_reset_o   <= 1'b1;
    end else begin
      // R01 pull pin low
      // R10 drive for sequence length
      reset_in_n_oe_o <= bidir_seq_reg && rpd_reg
                         && state_reg == rsc_pkg::RSC_SEQ;
      // R02 release after end of init
      if (state_reg != rsc_pkg::RSC_IDLE
          && state_reg != rsc_pkg::RSC_INIT) begin
        reset_out_n_o <= 1'b0;
      end else if (end_of_init_instr_i
                   && state_reg == rsc_pkg::RSC_INIT) begin
        reset_out_n_o <= 1'b1;
      end
      // R05 pulldown follows reset pin
      rpd_pulldown_o <= !filt_n;
      // R03 pullup after sequence
      if (state_reg == rsc_pkg::RSC_CHECK) begin
        rpd_pullup_o <= powerdown_pullup_config_i;
      end else if (state_reg != rsc_pkg::RSC_INIT
                   && state_reg != rsc_pkg::RSC_IDLE) begin
        rpd_pullup_o <= 1'b0;
      end
      core_reset_o  <= state_reg != rsc_pkg::RSC_IDLE
                       && state_reg != rsc_pkg::RSC_INIT;
      async_reset_o <= state_reg == rsc_pkg::RSC_ASYNC;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_async_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    ((state_reg == rsc_pkg::RSC_IDLE || state_reg == rsc_pkg::RSC_INIT)
     && !filt_n && !rpd_reg)
    |=> state_reg == rsc_pkg::RSC_ASYNC) else $error("no async entry"); // R04
  a_sync_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    ((state_reg == rsc_pkg::RSC_IDLE || state_reg == rsc_pkg::RSC_INIT)
     && !filt_n && rpd_reg)
    |=> state_reg == rsc_pkg::RSC_SYNC) else $error("no sync entry"); // R06
  a_short_flags: assert property (@(posedge clk_i) disable iff (rst_i) // R09
    (state_reg == rsc_pkg::RSC_SYNC) |=> flags_o == rsc_pkg::FLAGS_SHORT)
    else $error("sync reset not flagged short");
  a_pd_switch: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == rsc_pkg::RSC_SEQ && !filt_n && !rpd_reg && !sw_seq_reg)
    |=> state_reg == rsc_pkg::RSC_ASYNC) else $error("no async switch"); // R07
  a_pulldown: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> rpd_pulldown_o == !$past(filt_n)) else $error("pulldown"); // R05
  a_out_held: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == rsc_pkg::RSC_SEQ) |=> !reset_out_n_o)
    else $error("reset out released early"); // R02
  a_bidir_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == rsc_pkg::RSC_SEQ) |=> !bidir_reset_enable_o)
    else $error("bidir not cleared"); // R11
  a_check_len: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state_reg == rsc_pkg::RSC_CHECK)
    |-> (state_reg == rsc_pkg::RSC_CHECK)[*8]) else $error("check len"); // R12
  a_async_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == rsc_pkg::RSC_ASYNC && !pon_reg)
    |=> flags_o == rsc_pkg::FLAGS_LONG) else $error("async flags"); // R08
  a_drive_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    reset_in_n_oe_o |-> $past(state_reg) == rsc_pkg::RSC_SEQ)
    else $error("pin driven outside sequence"); // R01
  c_sync: cover property (@(posedge clk_i) disable iff (rst_i)
    state_reg == rsc_pkg::RSC_SYNC);
  c_resample: cover property (@(posedge clk_i) disable iff (rst_i)
    state_reg == rsc_pkg::RSC_CHECK ##1 state_reg == rsc_pkg::RSC_SYNC);
  c_drive: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(reset_in_n_oe_o));
endmodule

// ===== dv/rsc_rc_net.sv
// rsc_rc_net: board-side model of the reset pin and powerdown capacitor.
// assumes both pins sampled on clk_i; a pull-up holds the reset pin high.
`timescale 1ns/10ps
module rsc_rc_net #(
  parameter int unsigned CAP_MAX = 1600
) (
  input  wire logic clk_i,
  input  wire logic ext_low_i,
  input  wire logic oe_i,
  input  wire logic pulldown_i,
  output logic      pin_n_o,
  output logic      rpd_o
);
  // capacitor starts discharged, as at power-up
  logic [11:0] charge_reg = 12'h000;

  // wired-or of board switch and device open drain
  assign pin_n_o = !(ext_low_i || oe_i);
  assign rpd_o   = (charge_reg >= CAP_MAX[11:0] / 12'h002);

  always_ff @(posedge clk_i) begin
    if (pulldown_i && charge_reg != 12'h000) begin
      charge_reg <= charge_reg - 12'h001;
    end else if (!pulldown_i && charge_reg < CAP_MAX[11:0]) begin
      charge_reg <= charge_reg + 12'h001;
    end
  end
endmodule

// ===== dv/reset_source_classifier_test.sv
// reset_source_classifier_test: self-checking bench for rsc_top.
// assumes rsc_rc_net stands for the board; short counts via parameters.
`timescale 1ns/10ps
module reset_source_classifier_test;
  typedef struct {
    int unsigned         hold;
    logic                cfg;
    logic                async;
    rsc_pkg::rsc_flags_t flags;
  } rsc_row_t;

  rsc_row_t rows [3] = '{
    '{150, 1'b0, 1'b0, rsc_pkg::FLAGS_SHORT},
    '{500, 1'b1, 1'b0, rsc_pkg::FLAGS_LONG},
    '{1500, 1'b1, 1'b1, rsc_pkg::FLAGS_LONG}};

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ext_low = 1'b0;
  logic end_of_init_instr_i = 1'b0;
  logic bidir_set_i = 1'b0;
  logic powerdown_pullup_config_i = 1'b0;
  logic soft_req_i = 1'b0;
  logic wdog_req_i = 1'b0;
  localparam int SEQ_CYC = 16;
  int n_oe = 0;
  logic pin_n, reset_powerdown_pin, seen;
  logic reset_in_n_o, reset_in_n_oe_o, reset_out_n_o, rpd_pulldown_o;
  logic rpd_pullup_o, core_reset_o, async_reset_o, bidir_reset_enable_o;
  rsc_pkg::rsc_flags_t flags_o;
  int num_errors = 0;
  int comparisons = 0;

  always #2.5 clk_i = ~clk_i;

  rsc_top #(.LONG_CYC(300), .SEQ_CYC(SEQ_CYC)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .reset_in_n_i(pin_n),
    .reset_powerdown_pin_i(reset_powerdown_pin), .end_of_init_instr_i(end_of_init_instr_i),
    .bidir_set_i(bidir_set_i),
    .powerdown_pullup_config_i(powerdown_pullup_config_i),
    .soft_req_i(soft_req_i), .wdog_req_i(wdog_req_i),
    .reset_in_n_o(reset_in_n_o), .reset_in_n_oe_o(reset_in_n_oe_o),
    .reset_out_n_o(reset_out_n_o), .rpd_pulldown_o(rpd_pulldown_o),
    .rpd_pullup_o(rpd_pullup_o), .core_reset_o(core_reset_o),
    .async_reset_o(async_reset_o),
    .bidir_reset_enable_o(bidir_reset_enable_o), .flags_o(flags_o));

  rsc_rc_net board (
    .clk_i(clk_i), .ext_low_i(ext_low), .oe_i(reset_in_n_oe_o),
    .pulldown_i(rpd_pulldown_o), .pin_n_o(pin_n), .rpd_o(reset_powerdown_pin));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] got,
                       input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (core_reset_o !== 1'b0) begin
      @(negedge clk_i);
      n++;
      if (n > 8000) begin
        num_errors++;
        end_sim();
      end
    end
  endtask

  task automatic init_end();
    check("reset_out_low", {7'h00, reset_out_n_o}, 8'h00);
    end_of_init_instr_i = 1'b1;
    @(negedge clk_i);
    end_of_init_instr_i = 1'b0;
    repeat (3) @(negedge clk_i);
    check("reset_out_high", {7'h00, reset_out_n_o}, 8'h01);
  endtask

  task automatic run_row(input rsc_row_t r);
    seen = 1'b0;
    powerdown_pullup_config_i = r.cfg;
    ext_low = 1'b1;
    repeat (r.hold) begin
      @(negedge clk_i);
      seen = seen | async_reset_o;
    end
    check("pulldown_on", {7'h00, rpd_pulldown_o}, 8'h01);
    ext_low = 1'b0;
    check("async_seen", {7'h00, seen}, {7'h00, r.async});
    repeat (2) @(negedge clk_i);
    wait_idle();
    check("flags", {3'h0, flags_o}, {3'h0, r.flags});
    check("pullup", {7'h00, rpd_pullup_o}, {7'h00, r.cfg});
    check("pulldown_off", {7'h00, rpd_pulldown_o}, 8'h00);
    init_end();
    repeat (1800) @(negedge clk_i);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk_i);
    check("pon_flags", {3'h0, flags_o}, {3'h0, rsc_pkg::FLAGS_PON});
    check("open_drain_low", {7'h00, reset_in_n_o}, 8'h00);
    rst_i = 1'b0;
    wait_idle();
    bidir_set_i = 1'b1;
    @(negedge clk_i);
    bidir_set_i = 1'b0;
    repeat (3) @(negedge clk_i);
    check("bidir_set", {7'h00, bidir_reset_enable_o}, 8'h01);
    init_end();
    repeat (1800) @(negedge clk_i);
    soft_req_i = 1'b1;
    @(negedge clk_i);
    soft_req_i = 1'b0;
    seen = 1'b0;
    repeat (40) begin
      @(negedge clk_i);
      seen = seen | reset_in_n_oe_o;
      if (reset_in_n_oe_o === 1'b1) begin
        n_oe++;
      end
    end
    check("bidir_pull", {7'h00, seen}, 8'h01);
    check("bidir_len", 8'(n_oe), 8'(SEQ_CYC));
    wait_idle();
    check("soft_flags", {3'h0, flags_o}, 8'h02);
    check("pin_released", {7'h00, reset_in_n_oe_o}, 8'h00);
    check("bidir_clear", {7'h00, bidir_reset_enable_o}, 8'h00);
    init_end();
    repeat (1800) @(negedge clk_i);
    // pulse below the filter width must leave the core running
    ext_low = 1'b1;
    repeat (40) @(negedge clk_i);
    ext_low = 1'b0;
    seen = 1'b0;
    repeat (150) begin
      @(negedge clk_i);
      seen = seen | core_reset_o;
    end
    check("glitch_ignored", {7'h00, seen}, 8'h00);
    // input still low when a soft sequence ends: resampled as hardware
    ext_low = 1'b1;
    repeat (90) @(negedge clk_i);
    soft_req_i = 1'b1;
    @(negedge clk_i);
    soft_req_i = 1'b0;
    repeat (150) @(negedge clk_i);
    ext_low = 1'b0;
    repeat (2) @(negedge clk_i);
    wait_idle();
    check("resample_flags", {3'h0, flags_o},
          {3'h0, rsc_pkg::FLAGS_SHORT});
    init_end();
    repeat (1800) @(negedge clk_i);
    // watchdog request is a synchronous sequence with its own flag
    wdog_req_i = 1'b1;
    @(negedge clk_i);
    wdog_req_i = 1'b0;
    repeat (2) @(negedge clk_i);
    wait_idle();
    check("wdog_flags", {3'h0, flags_o}, 8'h03);
    init_end();
    for (int i = 0; i < 3; i++) begin
      run_row(rows[i]);
    end
    end_sim();
  end
endmodule
